// file: design/ebc_pkg.sv
// ebc_pkg: constants for the board control register (upper byte logic)
// assumes a 16-bit host i/o bus with an odd/even byte lane split
`default_nettype none
package ebc_pkg;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [15:0] BOARD_CONTROL_OFFSET = 16'h000A;
  localparam logic [15:0] BOARD_CONTROL_RESET  = 16'h0000;
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int SYS_CTRL_BIT   = 15;
  localparam int BUS_LOCK_BIT   = 14;
  localparam int FAIR_REQ_BIT   = 13;
  localparam int BYTE_SWAP_BIT  = 12;
  localparam int CHAN_CHK_BIT   = 11;
  localparam int SHMEM_N_BIT    = 10;
  localparam int MDMA_REQ_BIT   = 9;
endpackage : ebc_pkg
`default_nettype wire

// file: design/ebc_board_control.sv
// ebc_board_control: write-only board control register and its effects
// assumes host i/o strobes are synchronous to I_CLK and one cycle long
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RQ1] register at i/o base plus 0A, write-only, byte or word writes taken
// [RQ2] bit 15 set makes this board the extension bus system controller
// [RQ3] bit 14 set holds bus busy through master transfers; clear releases
// [RQ4] bit 13 set requests the bus as a fair requester
// [RQ5] bit 13 clear leaves priority fixed by daisy-chain position
// [RQ6] bit 12 set swaps bytes in each word on multibyte master transfers
// [RQ7] bit 11 set drives host channel-check line on master exceptions
// [RQ8] bit 10 is shown to other devices as the shared-memory flag
// [RQ9] bit 9 set drives the host dma request during master block moves
// [RQ10] bit 9 clear releases the host dma request line to high impedance
// [RQ11] software sets bit 9 before any master block transfer using dma
// [RQ12] hard reset clears bits 15 down to 9
// [RQ13] lower byte is stored and handed to the interrupt logic
module ebc_board_control #(
  parameter logic [15:0] IO_BASE = 16'h0000    // host i/o base address
) (
  input  wire logic        I_CLK,              // system clock, 10 MHz
  input  wire logic        I_NRST,             // sync reset, active low
  input  wire logic [15:0] I_IO_ADDR,          // host i/o address
  input  wire logic        I_IO_WR,            // host write strobe
  input  wire logic        I_IO_BHE,           // odd (high) byte lane enable
  input  wire logic        I_IO_BLE,           // even (low) byte lane enable
  input  wire logic [15:0] I_IO_WDATA,         // host write data
  input  wire logic        I_MST_XFER,         // master transfer in progress
  input  wire logic        I_MST_BLOCK,        // master block transfer active
  input  wire logic        I_MST_DRQ,          // block engine dma request
  input  wire logic        I_MST_EXC,          // master exception condition
  input  wire logic [15:0] I_MST_DATA,         // master transfer data word
  input  wire logic        I_MST_MULTI,        // master transfer is multibyte
  output logic             O_SYS_CONTROLLER,   // act as system controller
  output logic             O_BUSY_HOLD,        // hold bus busy asserted
  output logic             O_FAIR_REQ,         // fair requester mode
  output logic             O_POSITIONAL_PRI,   // daisy-chain priority mode
  output logic [15:0]      O_MST_DATA,         // master data, swapped or not
  output logic             O_CHAN_CHECK,       // host channel-check request
  output logic             O_SHMEM_UNSUP_N,    // shared-memory flag value
  output logic             O_DRQ_OUT,          // host dma request level
  output logic             O_DRQ_OE,           // host dma request enable
  output logic [7:0]       O_IRQ_ENABLES       // lower-byte interrupt enables
);

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  wire logic [15:0] reg_addr;
  wire logic        hit;
  wire logic        wr_hi;
  wire logic        wr_lo;

  assign reg_addr = 16'(IO_BASE + ebc_pkg::BOARD_CONTROL_OFFSET);
  assign hit      = I_IO_WR && (I_IO_ADDR == reg_addr);          // RQ1
  assign wr_hi    = hit && I_IO_BHE;                              // RQ1
  assign wr_lo    = hit && I_IO_BLE;                              // RQ1

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  logic [7:0] ctl_hi_reg;
  logic [7:0] ctl_lo_reg;

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      ctl_hi_reg <= ebc_pkg::BOARD_CONTROL_RESET[15:8];   // RQ12
      ctl_lo_reg <= ebc_pkg::BOARD_CONTROL_RESET[7:0];
    end else begin
      if (wr_hi) begin
        ctl_hi_reg <= I_IO_WDATA[15:8];                   // RQ1
      end
      if (wr_lo) begin
        ctl_lo_reg <= I_IO_WDATA[7:0];                    // RQ13
      end
    end
  end

  // ----------------------------------------------------------------------
  // field taps
  // ----------------------------------------------------------------------
  wire logic sys_controller_sel;
  wire logic bus_lock_hold;
  wire logic fair_request_sel;
  wire logic master_byte_swap;
  wire logic chan_check_irq_en;
  wire logic shared_mem_unsupported_n;
  wire logic master_dma_req_en;

  assign sys_controller_sel       = ctl_hi_reg[ebc_pkg::SYS_CTRL_BIT - 8];
  assign bus_lock_hold            = ctl_hi_reg[ebc_pkg::BUS_LOCK_BIT - 8];
  assign fair_request_sel         = ctl_hi_reg[ebc_pkg::FAIR_REQ_BIT - 8];
  assign master_byte_swap         = ctl_hi_reg[ebc_pkg::BYTE_SWAP_BIT - 8];
  assign chan_check_irq_en        = ctl_hi_reg[ebc_pkg::CHAN_CHK_BIT - 8];
  assign shared_mem_unsupported_n = ctl_hi_reg[ebc_pkg::SHMEM_N_BIT - 8];
  assign master_dma_req_en        = ctl_hi_reg[ebc_pkg::MDMA_REQ_BIT - 8];

  // ----------------------------------------------------------------------
  // effects
  // ----------------------------------------------------------------------
  wire logic        swap_now;
  wire logic [15:0] data_next;

  assign swap_now  = master_byte_swap && I_MST_MULTI;             // RQ6
  assign data_next = swap_now ? {I_MST_DATA[7:0], I_MST_DATA[15:8]}
                              : I_MST_DATA;                       // RQ6

  logic [15:0] mst_data_reg;
  logic        chan_check_reg;

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      mst_data_reg   <= 16'h0000;
      chan_check_reg <= 1'b0;
    end else begin
      mst_data_reg   <= data_next;
      chan_check_reg <= chan_check_irq_en && I_MST_EXC;           // RQ7
    end
  end

  assign O_SYS_CONTROLLER = sys_controller_sel;                   // RQ2
  assign O_BUSY_HOLD      = bus_lock_hold && I_MST_XFER;          // RQ3
  assign O_FAIR_REQ       = fair_request_sel;                     // RQ4
  assign O_POSITIONAL_PRI = !fair_request_sel;                    // RQ5
  assign O_MST_DATA       = mst_data_reg;
  assign O_CHAN_CHECK     = chan_check_reg;
  assign O_SHMEM_UNSUP_N  = shared_mem_unsupported_n;             // RQ8
  // the host line is shared: drive only while enabled in a block move
  assign O_DRQ_OE  = master_dma_req_en && I_MST_BLOCK;            // RQ9 RQ10
  assign O_DRQ_OUT = O_DRQ_OE && I_MST_DRQ;                       // RQ9
  assign O_IRQ_ENABLES    = ctl_lo_reg;                           // RQ13

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence hi_write_s;
    wr_hi;
  endsequence

  hi_byte_store_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    hi_write_s |=> ctl_hi_reg == $past(I_IO_WDATA[15:8])) // RQ1
    else $error("upper byte not stored on write");
  hold_no_write_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !wr_hi |=> $stable(ctl_hi_reg)) // RQ1
    else $error("upper byte changed without write");
  sysctl_follow_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    O_SYS_CONTROLLER == ctl_hi_reg[7]) // RQ2
    else $error("system controller output mismatch");
  busy_lock_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (ctl_hi_reg[6] && I_MST_XFER) |-> O_BUSY_HOLD) // RQ3
    else $error("busy not held while locked");
  busy_release_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !ctl_hi_reg[6] |-> !O_BUSY_HOLD) // RQ3
    else $error("busy held while unlocked");
  arb_mode_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    O_FAIR_REQ != O_POSITIONAL_PRI && O_FAIR_REQ == ctl_hi_reg[5]) // RQ4
    else $error("arbitration mode wrong");
  swap_data_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (ctl_hi_reg[4] && I_MST_MULTI) |=>
      O_MST_DATA == {$past(I_MST_DATA[7:0]), $past(I_MST_DATA[15:8])}) // RQ6
    else $error("bytes not swapped");
  pass_data_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !ctl_hi_reg[4] |=> O_MST_DATA == $past(I_MST_DATA)) // RQ6
    else $error("data altered without swap");
  chan_check_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (ctl_hi_reg[3] && I_MST_EXC) |=> O_CHAN_CHECK) // RQ7
    else $error("channel check missing");
  shmem_flag_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    O_SHMEM_UNSUP_N == ctl_hi_reg[2]) // RQ8
    else $error("shared memory flag mismatch");
  drq_drive_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (ctl_hi_reg[1] && I_MST_BLOCK) |-> O_DRQ_OE) // RQ9
    else $error("dma request not driven");
  drq_release_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !ctl_hi_reg[1] |-> !O_DRQ_OE && !O_DRQ_OUT) // RQ10
    else $error("dma request driven while disabled");
  reset_clear_a: assert property (@(posedge I_CLK)
    !I_NRST |=> ctl_hi_reg == 8'h00) // RQ12
    else $error("control bits not cleared by reset");

  // ----------------------------------------------------------------------
  // lower byte, decode misses and output gating
  // ----------------------------------------------------------------------
  sequence lo_write_s;
    wr_lo;
  endsequence

  lo_byte_store_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    lo_write_s |=> ctl_lo_reg == $past(I_IO_WDATA[7:0])) // RQ13
    else $error("lower byte not stored on write");
  lo_hold_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !wr_lo |=> $stable(ctl_lo_reg)) // RQ13
    else $error("lower byte changed without write");
  irq_follow_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    O_IRQ_ENABLES == ctl_lo_reg) // RQ13
    else $error("interrupt enables not handed on");
  addr_miss_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (I_IO_WR && I_IO_ADDR != reg_addr) |=>
      $stable(ctl_hi_reg) && $stable(ctl_lo_reg)) // RQ1
    else $error("write to other address changed register");
  chan_quiet_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !(ctl_hi_reg[3] && I_MST_EXC) |=> !O_CHAN_CHECK) // RQ7
    else $error("channel check raised without cause");
  swap_single_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !I_MST_MULTI |=> O_MST_DATA == $past(I_MST_DATA)) // RQ6
    else $error("single byte transfer altered");
  pos_pri_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !ctl_hi_reg[5] |-> O_POSITIONAL_PRI && !O_FAIR_REQ) // RQ5
    else $error("positional priority not selected");
  busy_idle_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !I_MST_XFER |-> !O_BUSY_HOLD) // RQ3
    else $error("busy held outside master transfer");
  drq_level_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (ctl_hi_reg[1] && I_MST_BLOCK && I_MST_DRQ) |-> O_DRQ_OUT) // RQ9
    else $error("dma request level not driven");
  drq_idle_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !I_MST_BLOCK |-> !O_DRQ_OE && !O_DRQ_OUT) // RQ10
    else $error("dma request driven outside block move");
  reset_outputs_a: assert property (@(posedge I_CLK)
    !I_NRST |=> ctl_lo_reg == 8'h00 && O_MST_DATA == 16'h0000 &&
      !O_CHAN_CHECK) // RQ12
    else $error("outputs not cleared by reset");

endmodule // ebc_board_control

`default_nettype wire

// file: verif/ebc_far_master.sv
// ebc_far_master: far-side master engine feeding the transfer inputs
// assumes the bench sets i_req just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ebc_far_master (
  input  wire logic        i_clk,  // bus clock
  input  wire logic [4:0]  i_req,  // xfer, block, drq, exc, multi
  input  wire logic [15:0] i_word, // word offered in a transfer
  output logic [4:0]       o_ctrl, // master-side control levels
  output logic [15:0]      o_data  // data lines
);
  logic [15:0] last_reg = 16'h0000;
  assign o_ctrl = i_req;
  // released lines show the inverse of the last word, never a stale copy
  assign o_data = i_req[4] ? i_word : ~last_reg;
  always_ff @(posedge i_clk) begin
    if (i_req[4]) last_reg <= i_word;
  end
endmodule // ebc_far_master
`default_nettype wire

// file: verif/test_extension_bus_board_control_upper.sv
// test_extension_bus_board_control_upper: self-checking bench
// assumes ebc_pkg, ebc_board_control and ebc_far_master compiled first
`timescale 1ns/1ps
`default_nettype none
module test_extension_bus_board_control_upper;
  localparam logic [15:0] HIT = 16'h0230 + ebc_pkg::BOARD_CONTROL_OFFSET;
  logic        I_CLK = 1'b0;
  logic        I_NRST = 1'b0;
  logic        I_IO_WR = 1'b0;
  logic [1:0]  lanes = 2'b00;
  logic [15:0] I_IO_ADDR = 16'h0000;
  logic [15:0] I_IO_WDATA = 16'h0000;
  logic [4:0]  req = 5'h00;
  logic [15:0] word = 16'h0000;
  logic [15:0] sh = 16'h0000;
  logic [31:0] q[$];
  wire logic [4:0]  ctrl;
  wire logic [15:0] mdata;
  wire logic [31:0] obs;
  int          seed = 32'h05f4_09b6;
  int          n_errors = 0;
  int          n_checks = 0;
  always #50 I_CLK = ~I_CLK;
  ebc_far_master far (.i_clk(I_CLK), .i_req(req), .i_word(word),
    .o_ctrl(ctrl), .o_data(mdata));
  ebc_board_control #(.IO_BASE(16'h0230)) uut (.I_CLK(I_CLK),
    .I_NRST(I_NRST), .I_IO_ADDR(I_IO_ADDR), .I_IO_WR(I_IO_WR),
    .I_IO_BHE(lanes[1]), .I_IO_BLE(lanes[0]), .I_IO_WDATA(I_IO_WDATA),
    .I_MST_XFER(ctrl[4]), .I_MST_BLOCK(ctrl[3]), .I_MST_DRQ(ctrl[2]),
    .I_MST_EXC(ctrl[1]), .I_MST_MULTI(ctrl[0]), .I_MST_DATA(mdata),
    .O_SYS_CONTROLLER(obs[31]), .O_BUSY_HOLD(obs[30]),
    .O_FAIR_REQ(obs[29]), .O_POSITIONAL_PRI(obs[28]),
    .O_CHAN_CHECK(obs[27]), .O_SHMEM_UNSUP_N(obs[26]),
    .O_DRQ_OUT(obs[25]), .O_DRQ_OE(obs[24]),
    .O_IRQ_ENABLES(obs[23:16]), .O_MST_DATA(obs[15:0]));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value outputs expected %h seen %h", want, seen);
    end
  endtask
  task automatic finish_test;
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // one step: drive, let the design take it, note the expected outputs
  // ----------------------------------------------------------------------
  task automatic step(input logic wr, input logic [1:0] ln,
    input logic [15:0] a, input logic [15:0] d, input logic [4:0] r,
    input logic rst);
    logic [15:0] md;
    logic        chk;
    logic        oe;
    @(posedge I_CLK);
    I_IO_WR <= wr;
    lanes <= ln;
    I_IO_ADDR <= a;
    I_IO_WDATA <= d;
    req <= r;
    I_NRST <= ~rst;
    word <= 16'($random(seed));
    @(posedge I_CLK);
    I_IO_WR <= 1'b0;
    md = (sh[12] && r[0]) ? {mdata[7:0], mdata[15:8]} : mdata;
    chk = sh[11] & r[1];
    if (wr && a == HIT && ln[1]) sh[15:8] = d[15:8];
    if (wr && a == HIT && ln[0]) sh[7:0] = d[7:0];
    if (rst) begin
      sh = 16'h0000;
      md = 16'h0000;
      chk = 1'b0;
    end
    oe = sh[9] & r[3];
    q.push_back({sh[15], sh[14] & r[4], sh[13], ~sh[13], chk, sh[10],
      oe & r[2], oe, sh[7:0], md});
  endtask
  always @(negedge I_CLK) begin
    if (q.size() > 0) check(obs, q.pop_front());
  end
  initial begin
    #2_000_000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (1) @(posedge I_CLK);
    step(1'b0, 2'b00, HIT, 16'hffff, 5'h1f, 1'b1);
    for (int b = 9; b < 16; b++) begin
      step(1'b1, 2'b11, HIT, 16'h0001 << b, 5'h00, 1'b0);
      step(1'b0, 2'b00, HIT, 16'h0000, 5'h1f, 1'b0);
      step(1'b0, 2'b00, HIT, 16'h0000, 5'h00, 1'b0);
    end
    step(1'b1, 2'b10, HIT, 16'h5a5a, 5'h1f, 1'b0);
    step(1'b1, 2'b01, HIT, 16'ha5a5, 5'h00, 1'b0);
    step(1'b1, 2'b11, HIT + 16'h0002, 16'hffff, 5'h1f, 1'b0);
    repeat (80) step(1'($random(seed)), 2'($random(seed)),
      (($random(seed) & 1) != 0) ? HIT : 16'($random(seed)),
      16'($random(seed)), 5'($random(seed)), 1'b0);
    step(1'b1, 2'b11, HIT, 16'hffff, 5'h1f, 1'b1);
    step(1'b0, 2'b00, HIT, 16'h0000, 5'h1f, 1'b0);
    repeat (2) @(negedge I_CLK);
    finish_test();
  end
endmodule // test_extension_bus_board_control_upper
`default_nettype wire
